/* logic/t1imk_pkg.sv */
// Package: register map, field positions and reset values of the mask block
package t1imk_pkg;
	// ----------------------------------------------------------------
	// Register byte addresses (printed offsets are not all multiples of
	// four, so each is an index and the byte address is four times it)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_MASK_ONE = 6'h1c;
	localparam logic [5:0] IDX_OVF_MASK = 6'h1d;
	localparam logic [5:0] IDX_MASK_THREE = 6'h1e;
	localparam logic [5:0] IDX_LINE_CTRL = 6'h1f;
	localparam logic [5:0] IDX_IRQ_CTRL = 6'h20;
	localparam logic [5:0] IDX_STAT_ONE = 6'h21;
	localparam logic [5:0] IDX_STAT_OVF = 6'h22;
	localparam logic [5:0] IDX_STAT_THREE = 6'h23;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_FRAMING = 7;
	localparam int BIT_NRZ = 7;
	localparam int BIT_EQ_OFF = 3;
	localparam int BIT_SUSPEND = 6;
	localparam int BIT_ACK = 5;
	localparam int BIT_DEBOUNCE = 0;
	localparam int BIT_ONE_SEC = 3;
	localparam int BIT_FIVE_SEC = 2;
	// ----------------------------------------------------------------
	// Implemented bits and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] MASK_ONE_USED = 8'hfe;
	localparam logic [7:0] MASK_THREE_USED = 8'h1f;
	localparam logic [7:0] IRQ_CTRL_USED = 8'h41;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] LINE_RESET = 8'h00;
endpackage

/* logic/t1imk_top.sv */
// Interrupt mask, pending status and line configuration block
`timescale 1ns/100ps
`default_nettype none
module t1imk_top
	import t1imk_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic terminal_sync_i,
	input wire logic framing_err_i,
	input wire logic crc6_err_i,
	input wire logic yellow_alarm_i,
	input wire logic align_change_i,
	input wire logic bipolar_viol_i,
	input wire logic b8zs_code_i,
	input wire logic prbs_err_i,
	input wire logic density_viol_i,
	input wire logic [7:0] cnt_wrap_i,
	input wire logic loopcode_48ms_i,
	input wire logic one_second_flag_i,
	input wire logic five_second_flag_i,
	input wire logic bit_message_new_i,
	input wire logic signaling_change_i,
	input wire logic signaling_change_db_i,
	input wire logic liu_disabled_i,
	input wire logic line_in_a_i,
	input wire logic line_in_b_i,
	input wire logic tx_data_i,
	output logic rx_data_o,
	output logic rx_bpv_o,
	output logic line_out_a_o,
	output logic line_out_b_o,
	output logic [2:0] tx_buildout_sel_o,
	output logic rx_equalizer_off_o,
	output logic [2:0] rx_equalization_sel_o,
	output logic signaling_debounce_en_o,
	output logic irq_n_o,
	output logic irq_n_oe_o
);
	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	logic rst_n;

	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	logic [7:0] mask_one_reg;
	logic [7:0] ovf_mask_reg;
	logic [7:0] mask_three_reg;
	logic [7:0] line_ctrl_reg;
	logic [7:0] irq_ctrl_reg;
	logic [7:0] stat_one_reg;
	logic [7:0] stat_ovf_reg;
	logic [7:0] stat_three_reg;
	logic [7:0] ev_one;
	logic [7:0] ev_three;
	logic one_sec_d_reg;
	logic five_sec_d_reg;
	logic wr_en;
	logic ack;
	logic suspend;
	logic [5:0] idx;
	logic mapped;
	logic [7:0] rd_byte;

	function automatic logic idx_ok(input logic [5:0] i);
		return (i >= IDX_MASK_ONE) && (i <= IDX_STAT_THREE);
	endfunction

	assign idx = paddr_i[7:2];
	assign mapped = idx_ok(idx) && (paddr_i[1:0] == 2'b00);
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped;
	assign wr_en = clk_en_i && psel_i && penable_i && pwrite_i && mapped;

	always_comb begin
		unique case (idx)
			IDX_MASK_ONE: rd_byte = mask_one_reg;
			IDX_OVF_MASK: rd_byte = ovf_mask_reg;
			IDX_MASK_THREE: rd_byte = mask_three_reg;
			IDX_LINE_CTRL: rd_byte = line_ctrl_reg;
			IDX_IRQ_CTRL: rd_byte = irq_ctrl_reg;
			IDX_STAT_ONE: rd_byte = stat_one_reg;
			IDX_STAT_OVF: rd_byte = stat_ovf_reg;
			IDX_STAT_THREE: rd_byte = stat_three_reg;
			default: rd_byte = 8'h00;
		endcase
	end

	// Read data registered at the setup phase; status may still change in
	// the access cycle, the value seen is that of the setup edge.
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			prdata_o <= 32'h0000_0000;
		end else if (clk_en_i && psel_i && !penable_i) begin
			prdata_o <= (mapped && !pwrite_i) ? {24'h000000, rd_byte} :
				32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Mask and control registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mask_one_reg <= MASK_RESET;
			ovf_mask_reg <= MASK_RESET;
			mask_three_reg <= MASK_RESET;
			line_ctrl_reg <= LINE_RESET;
			irq_ctrl_reg <= MASK_RESET;
		end else if (wr_en) begin
			unique case (idx)
				IDX_MASK_ONE: mask_one_reg <= pwdata_i[7:0] & MASK_ONE_USED;
				IDX_OVF_MASK: ovf_mask_reg <= pwdata_i[7:0];
				IDX_MASK_THREE: mask_three_reg <= pwdata_i[7:0] &
					MASK_THREE_USED;
				IDX_LINE_CTRL: line_ctrl_reg <= pwdata_i[7:0];
				IDX_IRQ_CTRL: irq_ctrl_reg <= pwdata_i[7:0] & IRQ_CTRL_USED;
				default: ;
			endcase
		end
	end

	// Acknowledge is a write-only strobe: it never stores, so it reads zero
	assign ack = wr_en && (idx == IDX_IRQ_CTRL) && pwdata_i[BIT_ACK];
	assign suspend = irq_ctrl_reg[BIT_SUSPEND];
	assign signaling_debounce_en_o = irq_ctrl_reg[BIT_DEBOUNCE];

	// ----------------------------------------------------------------
	// Event qualification
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			one_sec_d_reg <= 1'b0;
			five_sec_d_reg <= 1'b0;
		end else if (clk_en_i) begin
			one_sec_d_reg <= one_second_flag_i;
			five_sec_d_reg <= five_second_flag_i;
		end
	end

	always_comb begin
		ev_one = 8'h00;
		ev_one[7] = framing_err_i && terminal_sync_i;
		ev_one[6] = crc6_err_i;
		ev_one[5] = yellow_alarm_i;
		ev_one[4] = align_change_i;
		ev_one[3] = bipolar_viol_i && !b8zs_code_i;
		ev_one[2] = prbs_err_i;
		ev_one[1] = density_viol_i;
		ev_three = 8'h00;
		ev_three[4] = loopcode_48ms_i;
		ev_three[BIT_ONE_SEC] = one_second_flag_i && !one_sec_d_reg;
		ev_three[BIT_FIVE_SEC] = five_second_flag_i && !five_sec_d_reg;
		ev_three[1] = bit_message_new_i;
		ev_three[0] = signaling_debounce_en_o ? signaling_change_db_i :
			signaling_change_i;
	end

	// ----------------------------------------------------------------
	// Pending status: masked sources never latch, suspend ignores all.
	// A set in the acknowledge cycle wins so no event is lost.
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			stat_one_reg <= 8'h00;
			stat_ovf_reg <= 8'h00;
			stat_three_reg <= 8'h00;
		end else if (clk_en_i) begin
			if (suspend) begin
				stat_one_reg <= ack ? 8'h00 : stat_one_reg;
				stat_ovf_reg <= ack ? 8'h00 : stat_ovf_reg;
				stat_three_reg <= ack ? 8'h00 : stat_three_reg;
			end else begin
				stat_one_reg <= (ack ? 8'h00 : stat_one_reg) |
					(ev_one & mask_one_reg);
				stat_ovf_reg <= (ack ? 8'h00 : stat_ovf_reg) |
					(cnt_wrap_i & ovf_mask_reg);
				stat_three_reg <= (ack ? 8'h00 : stat_three_reg) |
					(ev_three & mask_three_reg);
			end
		end
	end

	// ----------------------------------------------------------------
	// Open-drain interrupt pin: enable low means driven (low)
	// ----------------------------------------------------------------
	logic pending;
	assign pending = |{stat_one_reg, stat_ovf_reg, stat_three_reg};
	assign irq_n_o = 1'b0;
	assign irq_n_oe_o = !(pending && !suspend);

	// ----------------------------------------------------------------
	// Line interface configuration and framer-only format
	// ----------------------------------------------------------------
	assign tx_buildout_sel_o = line_ctrl_reg[6:4];
	assign rx_equalizer_off_o = line_ctrl_reg[BIT_EQ_OFF];
	assign rx_equalization_sel_o = line_ctrl_reg[2:0];

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_data_o <= 1'b0;
			rx_bpv_o <= 1'b0;
			line_out_a_o <= 1'b0;
			line_out_b_o <= 1'b0;
		end else if (clk_en_i) begin
			if (liu_disabled_i && line_ctrl_reg[BIT_NRZ]) begin
				rx_data_o <= line_in_a_i;
				rx_bpv_o <= 1'b0;
				line_out_a_o <= 1'b0;
				line_out_b_o <= tx_data_i;
			end else begin
				rx_data_o <= line_in_a_i ^ line_in_b_i;
				rx_bpv_o <= line_in_a_i && line_in_b_i;
				line_out_a_o <= tx_data_i;
				line_out_b_o <= !tx_data_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence ack_write_s;
		ack && clk_en_i;
	endsequence

	framing_sync_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		clk_en_i && !suspend && !terminal_sync_i && !stat_one_reg[7]
		|=> !stat_one_reg[7])
		else $error("framing error latched without frame sync");
	mask_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		clk_en_i && !suspend && crc6_err_i && mask_one_reg[6]
		|=> stat_one_reg[6])
		else $error("unmasked crc event not latched");
	masked_block_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		clk_en_i && !mask_one_reg[3] && !stat_one_reg[3]
		|=> !stat_one_reg[3])
		else $error("masked violation latched");
	ack_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		ack_write_s ##0 (suspend || cnt_wrap_i == 8'h00) |=>
		stat_ovf_reg == 8'h00)
		else $error("acknowledge did not clear status");
	suspend_float_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		suspend |-> irq_n_oe_o)
		else $error("interrupt driven while suspended");
	irq_drive_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		clk_en_i && !suspend && ovf_mask_reg[0] && cnt_wrap_i[0]
		##1 !suspend |-> !irq_n_oe_o)
		else $error("overflow did not drive interrupt");
	sec_edge_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		clk_en_i && $past(clk_en_i) && $stable(one_second_flag_i) &&
		!suspend && !ack &&
		!stat_three_reg[3] |=> !stat_three_reg[3])
		else $error("one second level without edge latched");
	eq_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		rx_equalizer_off_o == line_ctrl_reg[3] &&
		rx_equalization_sel_o == line_ctrl_reg[2:0])
		else $error("equalizer controls disagree with register");

	// ----------------------------------------------------------------
	// Freeze, acknowledge, pending-status and line path checks
	// ----------------------------------------------------------------
	sequence frozen_s;
		!clk_en_i;
	endsequence

	// No source may be firing, or the acknowledge would not release
	sequence quiet_s;
		ev_one == 8'h00 && cnt_wrap_i == 8'h00 && ev_three == 8'h00;
	endsequence

	freeze_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		frozen_s |=> $stable(stat_one_reg) && $stable(stat_ovf_reg) &&
		$stable(stat_three_reg) && $stable(mask_one_reg))
		else $error("state moved while clock enable low");
	ack_release_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		ack_write_s ##0 quiet_s |=> irq_n_oe_o)
		else $error("acknowledge did not release interrupt");
	ack_set_wins_a: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n)
		ack_write_s ##0 (!suspend && crc6_err_i && mask_one_reg[6])
		|=> stat_one_reg[6])
		else $error("event lost to acknowledge");
	loopcode_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		clk_en_i && !suspend && loopcode_48ms_i && mask_three_reg[4]
		|=> stat_three_reg[4])
		else $error("unmasked loop code not latched");
	five_sec_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		clk_en_i && !suspend && five_second_flag_i && !five_sec_d_reg &&
		mask_three_reg[BIT_FIVE_SEC] |=> stat_three_reg[BIT_FIVE_SEC])
		else $error("five second edge not latched");
	b8zs_block_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		clk_en_i && b8zs_code_i && !stat_one_reg[3]
		|=> !stat_one_reg[3])
		else $error("substitution violation latched");
	ovf_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		clk_en_i && !ack |=>
		(stat_ovf_reg & $past(stat_ovf_reg)) == $past(stat_ovf_reg))
		else $error("pending overflow lost without acknowledge");
	irq_idle_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		!pending |-> irq_n_oe_o)
		else $error("interrupt driven with nothing pending");
	nrz_path_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		clk_en_i && liu_disabled_i && line_ctrl_reg[BIT_NRZ] |=>
		rx_data_o == $past(line_in_a_i) && !rx_bpv_o &&
		line_out_b_o == $past(tx_data_i))
		else $error("framer-only stream path wrong");
	// Dual-rail decode: a mark on both rails at once is a violation
	dual_path_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
		clk_en_i && !(liu_disabled_i && line_ctrl_reg[BIT_NRZ]) |=>
		rx_bpv_o == ($past(line_in_a_i) && $past(line_in_b_i)) &&
		line_out_b_o == !$past(tx_data_i))
		else $error("dual-rail path wrong");
endmodule
`default_nettype wire

/* bench/t1imk_tb.sv */
// Self-checking testbench for the interrupt mask and line control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import t1imk_pkg::*;
	logic sys_clk_i = 1'b0, arst_n_i = 1'b0, clk_en_i = 1'b1;
	logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic terminal_sync_i = 1'b1, b8zs_code_i = 1'b0, liu_disabled_i = 1'b0;
	logic line_in_a_i = 1'b0, line_in_b_i = 1'b0, tx_data_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic pready_o, pslverr_o, err, rx_data_o, rx_bpv_o;
	logic line_out_a_o, line_out_b_o, rx_equalizer_off_o;
	logic signaling_debounce_en_o, irq_n_o, irq_n_oe_o;
	logic [2:0] tx_buildout_sel_o, rx_equalization_sel_o;
	logic framing_err_i, crc6_err_i, yellow_alarm_i, align_change_i;
	logic bipolar_viol_i, prbs_err_i, density_viol_i, loopcode_48ms_i;
	logic one_second_flag_i, five_second_flag_i, bit_message_new_i;
	logic signaling_change_i, signaling_change_db_i;
	logic [7:0] cnt_wrap_i;
	logic [7:0] ev [3] = '{8'h00, 8'h00, 8'h00};
	int num_errors = 0;
	int checked = 0;
	// ----------------------------------------------------------------
	// Event lanes follow the bit order of the three mask words
	// ----------------------------------------------------------------
	assign {framing_err_i, crc6_err_i, yellow_alarm_i, align_change_i,
		bipolar_viol_i, prbs_err_i, density_viol_i} = ev[0][7:1];
	assign cnt_wrap_i = ev[1];
	assign {loopcode_48ms_i, one_second_flag_i, five_second_flag_i,
		bit_message_new_i, signaling_change_i} = ev[2][4:0];
	assign signaling_change_db_i = ev[2][0];
	always #5 sys_clk_i = ~sys_clk_i;
	t1imk_top uut (.*);
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [5:0] idx,
		input logic [7:0] d);
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= {idx, 2'b00};
		pwdata_i <= {24'h0, d};
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		@(posedge sys_clk_i);
		while (pready_o !== 1'b1) @(posedge sys_clk_i);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		#1;
	endtask
	task automatic rd_chk(input string nm, input logic [5:0] idx,
		input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(nm, {24'h0, exp}, rd);
	endtask
	// One-cycle pulse, then let the status edge land before looking
	task automatic pulse(input int g, input int b);
		@(posedge sys_clk_i);
		ev[g][b] <= 1'b1;
		@(posedge sys_clk_i);
		ev[g][b] <= 1'b0;
		@(posedge sys_clk_i);
		#1;
	endtask
	task automatic ev_case(input int g, input int b, input logic [7:0] used);
		logic [5:0] idx;
		idx = IDX_MASK_ONE + 6'(g);
		apb(1'b1, idx, used & ~(8'h01 << b));
		pulse(g, b);
		chk("irq_oe masked", 32'h1, irq_n_oe_o);
		apb(1'b1, idx, 8'h01 << b);
		pulse(g, b);
		chk("irq_oe unmasked", 32'h0, irq_n_oe_o);
		chk("irq level", 32'h0, irq_n_o);
		rd_chk("status", idx + 6'h05, 8'h01 << b);
		apb(1'b1, IDX_IRQ_CTRL, 8'h20);
		@(posedge sys_clk_i);
		#1;
		chk("irq_oe after ack", 32'h1, irq_n_oe_o);
		rd_chk("status after ack", idx + 6'h05, 8'h00);
		rd_chk("ack self clear", IDX_IRQ_CTRL, 8'h00);
		apb(1'b1, idx, 8'h00);
	endtask
	task automatic line_step(input logic t, input logic a, input logic b);
		@(posedge sys_clk_i);
		tx_data_i <= t;
		line_in_a_i <= a;
		line_in_b_i <= b;
		repeat (2) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic reset_vals;
		for (int i = 0; i < 3; i++) begin
			rd_chk("mask reset", IDX_MASK_ONE + 6'(i), MASK_RESET);
		end
		rd_chk("line reset", IDX_LINE_CTRL, LINE_RESET);
		chk("buildout reset", 32'h0, tx_buildout_sel_o);
		chk("irq_oe reset", 32'h1, irq_n_oe_o);
	endtask
	task automatic regs_rw;
		for (int i = 0; i < 4; i++) apb(1'b1, IDX_MASK_ONE + 6'(i), 8'hff);
		rd_chk("mask one rw", IDX_MASK_ONE, MASK_ONE_USED);
		rd_chk("ovf mask rw", IDX_OVF_MASK, 8'hff);
		rd_chk("mask three rw", IDX_MASK_THREE, MASK_THREE_USED);
		chk("buildout 111", 32'h7, tx_buildout_sel_o);
		chk("eq off", 32'h1, rx_equalizer_off_o);
		chk("eq sel 111", 32'h7, rx_equalization_sel_o);
		apb(1'b1, IDX_LINE_CTRL, 8'h52);
		rd_chk("line rw", IDX_LINE_CTRL, 8'h52);
		chk("buildout 101", 32'h5, tx_buildout_sel_o);
		chk("eq on", 32'h0, rx_equalizer_off_o);
		chk("eq sel 010", 32'h2, rx_equalization_sel_o);
		apb(1'b1, IDX_IRQ_CTRL, 8'h01);
		chk("debounce en", 32'h1, signaling_debounce_en_o);
		apb(1'b0, 6'h3f, 8'h00);
		chk("unmapped read", 32'h0, rd);
		chk("unmapped err", 32'h1, err);
	endtask
	task automatic sync_cases;
		apb(1'b1, IDX_MASK_ONE, 8'h88);
		@(posedge sys_clk_i);
		terminal_sync_i <= 1'b0;
		b8zs_code_i <= 1'b1;
		pulse(0, 7);
		pulse(0, 3);
		chk("no sync or b8zs", 32'h1, irq_n_oe_o);
		@(posedge sys_clk_i);
		terminal_sync_i <= 1'b1;
		b8zs_code_i <= 1'b0;
	endtask
	task automatic freeze_case;
		apb(1'b1, IDX_MASK_ONE, 8'h40);
		@(posedge sys_clk_i);
		clk_en_i <= 1'b0;
		pulse(0, 6);
		chk("irq_oe frozen", 32'h1, irq_n_oe_o);
		@(posedge sys_clk_i);
		clk_en_i <= 1'b1;
		pulse(0, 6);
		chk("irq_oe thawed", 32'h0, irq_n_oe_o);
		apb(1'b1, IDX_IRQ_CTRL, 8'h20);
	endtask
	task automatic suspend_case;
		apb(1'b1, IDX_IRQ_CTRL, 8'h40);
		apb(1'b1, IDX_MASK_ONE, 8'h40);
		pulse(0, 6);
		chk("irq_oe suspended", 32'h1, irq_n_oe_o);
		rd_chk("status suspended", IDX_STAT_ONE, 8'h00);
		apb(1'b1, IDX_IRQ_CTRL, 8'h00);
		@(posedge sys_clk_i);
		#1;
		chk("dropped event", 32'h1, irq_n_oe_o);
		pulse(0, 6);
		chk("irq_oe resumed", 32'h0, irq_n_oe_o);
		apb(1'b1, IDX_IRQ_CTRL, 8'h20);
	endtask
	task automatic line_fmt;
		apb(1'b1, IDX_LINE_CTRL, 8'h80);
		@(posedge sys_clk_i);
		liu_disabled_i <= 1'b1;
		line_step(1'b1, 1'b1, 1'b0);
		chk("nrz out b high", 32'h1, line_out_b_o);
		chk("nrz rx high", 32'h1, rx_data_o);
		chk("nrz out a idle", 32'h0, line_out_a_o);
		chk("nrz bpv idle", 32'h0, rx_bpv_o);
		line_step(1'b0, 1'b0, 1'b1);
		chk("nrz out b low", 32'h0, line_out_b_o);
		chk("nrz rx low", 32'h0, rx_data_o);
		apb(1'b1, IDX_LINE_CTRL, 8'h00);
		line_step(1'b1, 1'b1, 1'b1);
		chk("dual out a", 32'h1, line_out_a_o);
		chk("dual out b", 32'h0, line_out_b_o);
		chk("dual rx", 32'h0, rx_data_o);
		chk("dual bpv", 32'h1, rx_bpv_o);
	endtask
	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge sys_clk_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		reset_vals;
		regs_rw;
		for (int b = 1; b < 8; b++) begin
			ev_case(0, b, MASK_ONE_USED);
		end
		for (int b = 0; b < 8; b++) begin
			ev_case(1, b, 8'hff);
		end
		for (int b = 0; b < 5; b++) begin
			ev_case(2, b, MASK_THREE_USED);
		end
		sync_cases;
		suspend_case;
		freeze_case;
		line_fmt;
		wrap_up;
	end
	initial begin
		#200000;
		num_errors++;
		wrap_up;
	end
endmodule
`default_nettype wire
